// File: shared/bsc_map.svh
// Offsets, field positions, reset values and codes of the bus state controller.
// Included by the controller top and its checker by bare name.
`ifndef BSC_MAP_SVH
`define BSC_MAP_SVH
`define BSC_NREG            3
`define BSC_NREGS           7
`define BSC_IDX_CTRL_ONE    3'h0
`define BSC_IDX_CTRL_TWO    3'h1
`define BSC_IDX_WAIT_CTRL   3'h2
`define BSC_IDX_MEM_CTRL    3'h3
`define BSC_IDX_RTC_STATUS  3'h4
`define BSC_IDX_RTC_COUNT   3'h5
`define BSC_IDX_RTC_COMPARE 3'h6
`define BSC_OFF_CTRL_ONE    32'hffffffe0
`define BSC_OFF_CTRL_TWO    32'hffffffe4
`define BSC_OFF_WAIT_CTRL   32'hffffffe8
`define BSC_OFF_MEM_CTRL    32'hffffffec
`define BSC_OFF_RTC_STATUS  32'hffffff60
`define BSC_OFF_RTC_COUNT   32'hfffffff4
`define BSC_OFF_RTC_COMPARE 32'h0ffffff8
`define BSC_HALF_OFFSET     32'h00000002
`define BSC_RST_CTRL_ONE    16'h03f0
`define BSC_RST_CTRL_TWO    16'h00fc
`define BSC_RST_WAIT_CTRL   16'haaff
`define BSC_RST_ZERO        16'h0000
`define BSC_WRITE_KEY       16'ha55a
`define BSC_CTRL_ONE_WMASK  16'h1ff7
`define BSC_BIT_MASTER      15
`define BSC_BIT_PSHR        10
`define BSC_MEMTYPE_LSB     0
`define BSC_MEMTYPE_W       3
`define BSC_BIT_SELFREF     0
`define BSC_MT_BASIC        3'h0
`define BSC_MT_SDRAM        3'h1
`define BSC_MT_DRAM         3'h2
`define BSC_MT_PSRAM        3'h3
`define BSC_STRAP_CYCLES    2'h3
`endif

// File: shared/bsc_pkg.sv
// Types shared by the bus state controller modules.
// Assumes nothing of its surroundings.
package bsc_pkg;
  typedef enum logic [1:0] {mode_total, mode_partial, mode_slave} bsc_mode_e;
  typedef enum {st_idle, st_request, st_own, st_released} bsc_arb_e;
  typedef enum {mem_basic, mem_sdram, mem_dram, mem_psram} bsc_mem_e;
endpackage : bsc_pkg

// File: shared/bsc_arb_if.sv
// Arbitration signals between the controller top and its arbiter.
// Assumes one clock domain, pclk.
`timescale 1ns/1ps
interface bsc_arb_if;
  bsc_pkg::bsc_mode_e mode;
  logic               need_bus;
  logic               core_idle;
  logic               arb_in;
  logic               arb_out;
  logic               own_bus;
  logic               released;
  modport ctrl (output mode, need_bus, core_idle, arb_in, input arb_out, own_bus, released);
  modport arb  (input mode, need_bus, core_idle, arb_in, output arb_out, own_bus, released);
endinterface : bsc_arb_if

// File: logic/bsc_sync.sv
// Two-flop synchroniser, one chain per bit.
// Assumes inputs asynchronous to pclk.
`timescale 1ns/1ps
module bsc_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_sync;

  always_comb begin
    next_stage1 = async_in;
    next_sync   = stage1;
  end

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        stage1[i]   <= 1'b0;
        sync_out[i] <= 1'b0;
      end else begin
        stage1[i]   <= next_stage1[i];
        sync_out[i] <= next_sync[i];
      end
    end
  end
endmodule : bsc_sync

// File: logic/bsc_arb.sv
// Bus arbitration state machine for the three arbitration modes.
// Assumes arb_in already synchronised and active high.
`timescale 1ns/1ps
module bsc_arb (
  input wire logic pclk,
  input wire logic presetn,
  bsc_arb_if.arb   bus
);
  bsc_pkg::bsc_arb_e state;
  bsc_pkg::bsc_arb_e next_state;

  always_comb begin
    next_state = state;
    case (state)
      bsc_pkg::st_idle: begin
        if (bus.mode == bsc_pkg::mode_total) begin
          next_state = bsc_pkg::st_own;
        end else if (bus.need_bus) begin
          next_state = bsc_pkg::st_request;
        end
      end
      bsc_pkg::st_request: begin
        if (bus.arb_in) begin
          next_state = bsc_pkg::st_own;
        end
      end
      bsc_pkg::st_own: begin
        if (bus.mode == bsc_pkg::mode_total) begin
          if (bus.arb_in && bus.core_idle) begin
            next_state = bsc_pkg::st_released;
          end
        end else if (!bus.need_bus && bus.core_idle) begin
          next_state = bsc_pkg::st_idle;
        end
      end
      bsc_pkg::st_released: begin
        if (!bus.arb_in) begin
          next_state = bsc_pkg::st_idle;
        end
      end
      default: next_state = bsc_pkg::st_idle;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= bsc_pkg::st_idle;
    end else begin
      state <= next_state;
    end
  end

  // Request held while owning; grant while released
  always_comb begin
    if (bus.mode == bsc_pkg::mode_total) begin
      bus.arb_out = (state == bsc_pkg::st_released);
    end else begin
      bus.arb_out = (state == bsc_pkg::st_request) || (state == bsc_pkg::st_own);
    end
    bus.own_bus  = (state == bsc_pkg::st_own);
    bus.released = (state == bsc_pkg::st_released)
                || (bus.mode == bsc_pkg::mode_slave && state != bsc_pkg::st_own);
  end
endmodule : bsc_arb

// File: logic/bsc_top.sv
// Bus state controller pin and register block: lane strobes, read pulse,
// arbitration pins, clock enable, DMA pins and the APB register bank.
// Assumes an access engine on pclk drives the core_* inputs.
//
// Overview of operation
// - Lane one pin role follows memory type
// - Lane zero pin role follows memory type
// - Read pulse low enables read data
// - Arbitration input: permission or release request
// - Arbitration output: request or grant
// - Clock enable drives synchronous DRAM self-refresh
// - Registers 16 bits, upper half reads zero
// - Word writes need key in upper half
// - Halfword accesses are read only
// - Halfword access decoded at address plus two
`timescale 1ns/1ps
`include "bsc_map.svh"
module bsc_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        master_strap,
  input  wire logic        core_cyc_active,
  input  wire logic        core_cyc_write,
  input  wire logic        core_col_strobe,
  input  wire logic [1:0]  core_lane_en,
  input  wire logic        core_read_strobe,
  input  wire logic        core_vector_fetch,
  input  wire logic        core_need_bus,
  input  wire logic        core_idle,
  input  wire logic [1:0]  core_dma_ack,
  output logic             core_wait,
  output logic             core_bus_owned,
  output logic [1:0]       core_dma_req,
  output logic [1:0]       lane_strobe_o,
  output logic [1:0]       lane_strobe_oe,
  output logic             read_pulse_n_o,
  output logic             read_pulse_oe,
  output logic             vector_fetch_flag_o,
  output logic             vector_fetch_flag_oe,
  input  wire logic        wait_n,
  input  wire logic        arb_in_n,
  output logic             arb_out_n,
  output logic             sdram_cke,
  input  wire logic        dma_request_zero_n,
  input  wire logic        dma_request_one_n,
  output logic             dma_acknowledge_zero,
  output logic             dma_acknowledge_one
);
  localparam int NR = `BSC_NREGS;

  bsc_arb_if arb_bus ();

  logic [4:0]  sync_q;
  logic [15:0] regs [NR];
  logic [15:0] next_regs [NR];
  logic        strap_q;
  logic        next_strap;
  logic [1:0]  strap_cnt;
  logic [1:0]  next_strap_cnt;
  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic [1:0]  next_lane;
  logic        next_rd_n;
  logic        next_vecf;
  logic        next_cke;
  logic [1:0]  next_dack;
  logic [1:0]  lane_q;
  logic        rd_n_q;
  logic        vecf_q;
  logic        cke_q;
  logic [1:0]  dack_q;
  logic [31:0] base_addr;
  logic        half_acc;
  logic        hit;
  logic [2:0]  hit_idx;
  logic        key_ok;
  logic        do_write;
  bsc_pkg::bsc_mem_e mem_type;

  function automatic logic [15:0] rst_val(input int i);
    case (i)
      0:       rst_val = `BSC_RST_CTRL_ONE;
      1:       rst_val = `BSC_RST_CTRL_TWO;
      2:       rst_val = `BSC_RST_WAIT_CTRL;
      default: rst_val = `BSC_RST_ZERO;
    endcase
  endfunction : rst_val

  bsc_sync #(
    .W (5)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({master_strap, ~dma_request_one_n, ~dma_request_zero_n, ~arb_in_n, ~wait_n}),
    .sync_out (sync_q)
  );

  bsc_arb u_arb (
    .pclk    (pclk),
    .presetn (presetn),
    .bus     (arb_bus)
  );

  // Address decode; halfword view sits two above the word view
  always_comb begin
    half_acc  = paddr[1];
    base_addr = paddr & ~`BSC_HALF_OFFSET;
    hit       = 1'b1;
    hit_idx   = `BSC_IDX_CTRL_ONE;
    case (base_addr)
      `BSC_OFF_CTRL_ONE:    hit_idx = `BSC_IDX_CTRL_ONE;
      `BSC_OFF_CTRL_TWO:    hit_idx = `BSC_IDX_CTRL_TWO;
      `BSC_OFF_WAIT_CTRL:   hit_idx = `BSC_IDX_WAIT_CTRL;
      `BSC_OFF_MEM_CTRL:    hit_idx = `BSC_IDX_MEM_CTRL;
      `BSC_OFF_RTC_STATUS:  hit_idx = `BSC_IDX_RTC_STATUS;
      `BSC_OFF_RTC_COUNT:   hit_idx = `BSC_IDX_RTC_COUNT;
      `BSC_OFF_RTC_COMPARE: hit_idx = `BSC_IDX_RTC_COMPARE;
      default:              hit = 1'b0;
    endcase
    key_ok   = (pwdata[31:16] == `BSC_WRITE_KEY);
    do_write = psel && penable && pwrite && hit && !half_acc
            && (pstrb == 4'hf) && key_ok;
  end

  // Register bank
  always_comb begin
    for (int i = 0; i < NR; i++) begin
      next_regs[i] = regs[i];
    end
    if (do_write) begin
      if (hit_idx == `BSC_IDX_CTRL_ONE) begin
        next_regs[hit_idx] = pwdata[15:0] & `BSC_CTRL_ONE_WMASK;
      end else begin
        next_regs[hit_idx] = pwdata[15:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NR; i++) begin
        regs[i] <= rst_val(i);
      end
    end else begin
      for (int i = 0; i < NR; i++) begin
        regs[i] <= next_regs[i];
      end
    end
  end

  // Mode strap caught a few cycles after reset release
  always_comb begin
    next_strap     = strap_q;
    next_strap_cnt = strap_cnt;
    if (strap_cnt != `BSC_STRAP_CYCLES) begin
      next_strap     = sync_q[4];
      next_strap_cnt = strap_cnt + 2'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_q   <= 1'b0;
      strap_cnt <= 2'h0;
    end else begin
      strap_q   <= next_strap;
      strap_cnt <= next_strap_cnt;
    end
  end

  // Read data and error prepared in the setup cycle
  always_comb begin
    next_prdata  = prdata;
    next_pslverr = pslverr;
    if (psel && !penable) begin
      next_prdata  = 32'h00000000;
      next_pslverr = !hit || (pwrite && half_acc);
      if (hit && !pwrite) begin
        next_prdata[15:0] = regs[hit_idx];
        if (hit_idx == `BSC_IDX_CTRL_ONE) begin
          next_prdata[`BSC_BIT_MASTER] = strap_q;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  assign pready = 1'b1;

  // Arbitration mode from strap and partial-share bit
  always_comb begin
    if (strap_q) begin
      arb_bus.mode = bsc_pkg::mode_slave;
    end else if (regs[`BSC_IDX_CTRL_ONE][`BSC_BIT_PSHR]) begin
      arb_bus.mode = bsc_pkg::mode_partial;
    end else begin
      arb_bus.mode = bsc_pkg::mode_total;
    end
    arb_bus.need_bus  = core_need_bus;
    arb_bus.core_idle = core_idle;
    arb_bus.arb_in    = sync_q[1];
    case (regs[`BSC_IDX_CTRL_ONE][`BSC_MEMTYPE_LSB +: `BSC_MEMTYPE_W])
      `BSC_MT_SDRAM: mem_type = bsc_pkg::mem_sdram;
      `BSC_MT_DRAM:  mem_type = bsc_pkg::mem_dram;
      `BSC_MT_PSRAM: mem_type = bsc_pkg::mem_psram;
      default:       mem_type = bsc_pkg::mem_basic;
    endcase
  end

  // Lane pin role per memory type
  for (genvar l = 0; l < 2; l++) begin : g_lane
    always_comb begin
      case (mem_type)
        bsc_pkg::mem_dram:  next_lane[l] = !(core_col_strobe && core_lane_en[l]);
        bsc_pkg::mem_sdram: next_lane[l] = !(core_cyc_active && core_lane_en[l]);
        default: next_lane[l] = !(core_cyc_active && core_cyc_write && core_lane_en[l]);
      endcase
    end
  end

  always_comb begin
    next_rd_n = !(core_read_strobe && !core_cyc_write);
    next_vecf = core_vector_fetch;
    next_cke  = !(mem_type == bsc_pkg::mem_sdram
               && regs[`BSC_IDX_MEM_CTRL][`BSC_BIT_SELFREF]);
    next_dack = core_dma_ack;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lane_q <= 2'h3;
      rd_n_q <= 1'b1;
      vecf_q <= 1'b0;
      cke_q  <= 1'b1;
      dack_q <= 2'h0;
    end else begin
      lane_q <= next_lane;
      rd_n_q <= next_rd_n;
      vecf_q <= next_vecf;
      cke_q  <= next_cke;
      dack_q <= next_dack;
    end
  end

  // Pins float in the released state, and in slave mode while the bus is not owned
  always_comb begin
    lane_strobe_o        = lane_q;
    lane_strobe_oe       = {2{!arb_bus.released}};
    read_pulse_n_o       = rd_n_q;
    read_pulse_oe        = !arb_bus.released;
    vector_fetch_flag_o  = vecf_q;
    vector_fetch_flag_oe = !arb_bus.released;
    arb_out_n            = !arb_bus.arb_out;
    core_wait            = sync_q[0] && !arb_bus.released;
    core_bus_owned       = arb_bus.own_bus;
    core_dma_req         = sync_q[3:2];
    sdram_cke            = cke_q;
    dma_acknowledge_zero = dack_q[0];
    dma_acknowledge_one  = dack_q[1];
  end
endmodule : bsc_top

// File: tb/bsc_top_monitor.sv
// Checker on the controller top ports.
// Assumes it is bound to bsc_top, single clock pclk.
`timescale 1ns/1ps
`include "bsc_map.svh"
module bsc_top_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        core_cyc_active,
  input wire logic [1:0]  core_lane_en,
  input wire logic        core_bus_owned,
  input wire logic        core_wait,
  input wire logic [1:0]  lane_strobe_o,
  input wire logic [1:0]  lane_strobe_oe,
  input wire logic        read_pulse_n_o,
  input wire logic        read_pulse_oe,
  input wire logic        vector_fetch_flag_oe,
  input wire logic        wait_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_lane1_idle;
    $past(!(core_cyc_active && core_lane_en[1])) |-> lane_strobe_o[1];
  endproperty
  a_lane1_idle: assert property (p_lane1_idle)
    else $error("lane one strobe active without a lane access");
  property p_lane0_idle;
    $past(!(core_cyc_active && core_lane_en[0])) |-> lane_strobe_o[0];
  endproperty
  a_lane0_idle: assert property (p_lane0_idle)
    else $error("lane zero strobe active without a lane access");
  property p_read_driven;
    !read_pulse_n_o |-> read_pulse_oe;
  endproperty
  a_read_driven: assert property (p_read_driven)
    else $error("read pulse low while floating");
  property p_upper_zero;
    psel && penable && !pwrite |-> prdata[31:16] == 16'h0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("upper half of read data not zero");
  property p_half_write;
    psel && penable && pwrite && paddr[1:0] == 2'h2 |-> pslverr;
  endproperty
  a_half_write: assert property (p_half_write)
    else $error("halfword write not refused");
  property p_half_read;
    psel && penable && !pwrite && paddr == `BSC_OFF_WAIT_CTRL + `BSC_HALF_OFFSET |-> !pslverr;
  endproperty
  a_half_read: assert property (p_half_read)
    else $error("halfword read refused");
  property p_own_drive;
    core_bus_owned |-> read_pulse_oe && vector_fetch_flag_oe && lane_strobe_oe == 2'h3;
  endproperty
  a_own_drive: assert property (p_own_drive)
    else $error("pins floating while bus owned");
  property p_float_all;
    !read_pulse_oe |-> lane_strobe_oe == 2'h0 && !vector_fetch_flag_oe;
  endproperty
  a_float_all: assert property (p_float_all)
    else $error("pins not floated together");
  property p_wait_own;
    core_bus_owned && $past(!wait_n) && $past(!wait_n, 2) && $past(!wait_n, 3) |-> core_wait;
  endproperty
  a_wait_own: assert property (p_wait_own)
    else $error("wait input lost while bus owned");
endmodule : bsc_top_monitor
bind bsc_top bsc_top_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
  .pslverr, .core_cyc_active, .core_lane_en, .core_bus_owned, .core_wait, .lane_strobe_o,
  .lane_strobe_oe, .read_pulse_n_o, .read_pulse_oe, .vector_fetch_flag_oe, .wait_n);

// File: tb/bsc_ext_master.sv
// Other bus master and external read buffer on the arbitration pins.
// Assumes active-low arbitration pins changed after pclk edges.
`timescale 1ns/1ps
module bsc_ext_master #(
  parameter int DELAY = 3
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic permit_mode,
  input  wire logic want_bus,
  input  wire logic arb_out_n,
  input  wire logic read_pulse_n_o,
  input  wire logic read_pulse_oe,
  output logic      arb_in_n,
  output logic      buf_drive
);
  int cnt;
  // Permission DELAY cycles after a request, else release request on demand
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt      <= 0;
      arb_in_n <= 1'b1;
    end else begin
      cnt      <= arb_out_n ? 0 : (cnt < DELAY ? cnt + 1 : cnt);
      arb_in_n <= permit_mode ? !(cnt == DELAY && !arb_out_n) : !want_bus;
    end
  end
  assign buf_drive = read_pulse_oe && !read_pulse_n_o;
endmodule : bsc_ext_master

// File: tb/bsc_top_bench.sv
// Self-checking bench of the controller top over APB and its pins.
// Assumes the peer model and the bound checker.
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module bsc_top_bench;
  localparam logic [15:0] KEY = 16'ha55a;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, core_wait;
  logic [31:0] paddr, pwdata, prdata;
  logic [3:0]  pstrb;
  logic        core_cyc_active, core_cyc_write, core_col_strobe, core_read_strobe;
  logic        core_vector_fetch, core_need_bus, core_idle, core_bus_owned, arb_in_n;
  logic [1:0]  core_lane_en, core_dma_ack, core_dma_req, lane_strobe_o, lane_strobe_oe;
  logic        read_pulse_n_o, read_pulse_oe, vector_fetch_flag_o, vector_fetch_flag_oe;
  logic        wait_n, arb_out_n, sdram_cke, dma_request_zero_n, dma_request_one_n;
  logic        dma_acknowledge_zero, dma_acknowledge_one, permit_mode, want_bus, buf_drive;
  logic        master_strap;
  int          miscompares, n_tests, cycles;
  logic [31:0] offs [7] = '{32'hffffffe0, 32'hffffffe4, 32'hffffffe8, 32'hffffffec,
                            32'hffffff60, 32'hfffffff4, 32'h0ffffff8};
  logic [15:0] rst  [7] = '{16'h03f0, 16'h00fc, 16'haaff, 16'h0, 16'h0, 16'h0, 16'h0};
  bsc_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .master_strap, .core_cyc_active, .core_cyc_write,
    .core_col_strobe, .core_lane_en, .core_read_strobe, .core_vector_fetch, .core_need_bus,
    .core_idle, .core_dma_ack, .core_wait, .core_bus_owned, .core_dma_req, .lane_strobe_o,
    .lane_strobe_oe, .read_pulse_n_o, .read_pulse_oe, .vector_fetch_flag_o,
    .vector_fetch_flag_oe, .wait_n, .arb_in_n, .arb_out_n, .sdram_cke, .dma_request_zero_n,
    .dma_request_one_n, .dma_acknowledge_zero, .dma_acknowledge_one);
  bsc_ext_master u_peer (.pclk, .presetn, .permit_mode, .want_bus, .arb_out_n,
    .read_pulse_n_o, .read_pulse_oe, .arb_in_n, .buf_drive);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task report_and_stop;
    if (miscompares == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] r, output logic e);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rd_chk(string n, input logic [31:0] a, input logic [31:0] x, input logic ex);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, 4'hf, r, e);
    `CHK(n, x, r)
    `CHK(n, ex, e)
  endtask : rd_chk
  task automatic wr(input logic [31:0] a, input logic [15:0] k, input logic [15:0] d,
                    input logic [3:0] s, input logic ex);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, {k, d}, s, r, e);
    `CHK("wr_err", ex, e)
  endtask : wr
  function automatic logic [1:0] exp_lane(int m, logic [3:0] p);
    logic act;
    case (m)
      1: act = 1'b1;
      2: act = p[1];
      default: act = p[0];
    endcase
    return ~({2{act}} & p[3:2]);
  endfunction : exp_lane
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {core_cyc_active, core_cyc_write, core_col_strobe, core_lane_en, core_read_strobe} = '0;
    {core_vector_fetch, core_need_bus, core_dma_ack, permit_mode, want_bus, master_strap} = '0;
    {core_idle, wait_n, dma_request_zero_n, dma_request_one_n} = 4'hf;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    for (int i = 0; i < 7; i++) begin
      rd_chk("reset", offs[i], {16'h0, rst[i]}, 1'b0);
      rd_chk("half", offs[i] + 32'h2, {16'h0, rst[i]}, 1'b0);
    end
    rd_chk("unmapped", 32'hffffff00, 32'h0, 1'b1);
    for (int i = 1; i < 7; i++) begin
      wr(offs[i], 16'h5aa5, 16'h1234, 4'hf, 1'b0);
      wr(offs[i], KEY, 16'h1234, 4'h3, 1'b0);
      wr(offs[i] + 32'h2, KEY, 16'h1234, 4'hf, 1'b1);
      rd_chk("refused", offs[i], {16'h0, rst[i]}, 1'b0);
      wr(offs[i], KEY, 16'h1234, 4'hf, 1'b0);
      rd_chk("keyed", offs[i], 32'h1234, 1'b0);
    end
    // Memory interface set up before any traffic
    wr(offs[0], KEY, 16'hffff, 4'hf, 1'b0);
    rd_chk("ctrl_one", offs[0], 32'h1ff7, 1'b0);
    for (int m = 0; m < 4; m++) begin
      wr(offs[0], KEY, 16'(m), 4'hf, 1'b0);
      wr(offs[3], KEY, 16'h0001, 4'hf, 1'b0);
      repeat (2) @(posedge pclk);
      `CHK("cke_self", (m != 1), sdram_cke)
      for (int p = 0; p < 16; p++) begin
        core_cyc_active    <= 1'b1;
        core_cyc_write     <= p[0];
        core_col_strobe    <= p[1];
        core_lane_en       <= p[3:2];
        core_read_strobe   <= ~p[0];
        core_vector_fetch  <= p[1];
        core_dma_ack       <= p[3:2];
        dma_request_zero_n <= p[2];
        dma_request_one_n  <= p[3];
        repeat (3) @(posedge pclk);
        `CHK("lanes", exp_lane(m, 4'(p)), lane_strobe_o)
        `CHK("read_pulse", p[0], read_pulse_n_o)
        `CHK("buffer", ~p[0], buf_drive)
        `CHK("vector_fetch", p[1], vector_fetch_flag_o)
        `CHK("dma_ack", p[3:2], {dma_acknowledge_one, dma_acknowledge_zero})
        `CHK("dma_req", ~p[3:2], core_dma_req)
      end
      core_cyc_active <= 1'b0;
      core_col_strobe <= 1'b0;
      core_lane_en    <= 2'h0;
      wr(offs[3], KEY, 16'h0000, 4'hf, 1'b0);
      repeat (2) @(posedge pclk);
      `CHK("cke_run", 1'b1, sdram_cke)
    end
    want_bus <= 1'b1;
    wait_n   <= 1'b0;
    while (read_pulse_oe !== 1'b0) @(posedge pclk);
    repeat (2) @(posedge pclk);
    `CHK("grant", 1'b0, arb_out_n)
    `CHK("float", 3'b000, {lane_strobe_oe, vector_fetch_flag_oe})
    `CHK("wait_ignored", 1'b0, core_wait)
    want_bus <= 1'b0;
    while (core_bus_owned !== 1'b1) @(posedge pclk);
    repeat (3) @(posedge pclk);
    `CHK("regain", 5'h1f, {lane_strobe_oe, read_pulse_oe, vector_fetch_flag_oe, arb_out_n})
    `CHK("wait_own", 1'b1, core_wait)
    wait_n <= 1'b1;
    wr(offs[0], KEY, 16'h0400, 4'hf, 1'b0);
    while (arb_out_n !== 1'b1) @(posedge pclk);
    permit_mode   <= 1'b1;
    core_idle     <= 1'b0;
    core_need_bus <= 1'b1;
    while (arb_out_n !== 1'b0) @(posedge pclk);
    `CHK("no_permit", 1'b0, core_bus_owned)
    while (core_bus_owned !== 1'b1) @(posedge pclk);
    `CHK("permit", 1'b0, arb_in_n)
    `CHK("req_held", 1'b0, arb_out_n)
    core_need_bus <= 1'b0;
    core_idle     <= 1'b1;
    while (core_bus_owned !== 1'b0) @(posedge pclk);
    repeat (2) @(posedge pclk);
    `CHK("req_drop", 1'b1, arb_out_n)
    // Slave strap needs a fresh reset to be captured
    master_strap <= 1'b1;
    presetn      <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rd_chk("strap", offs[0], 32'h000083f0, 1'b0);
    `CHK("slave_idle", 2'b01, {read_pulse_oe, arb_out_n})
    core_need_bus <= 1'b1;
    core_idle     <= 1'b0;
    while (core_bus_owned !== 1'b1) @(posedge pclk);
    `CHK("slave_own", 2'b10, {read_pulse_oe, arb_out_n})
    report_and_stop();
  end
endmodule : bsc_top_bench
